// ---- logic/ard_params.svh ----
/*
 Address map, field positions, reset values and counts of the converter
 debug-support block. Assumes inclusion by bare name.
*/
`ifndef ARD_PARAMS_SVH
`define ARD_PARAMS_SVH

`define ARD_AW          8
`define ARD_CW          10
`define ARD_DW          12
`define ARD_A_CTRL0     8'h00
`define ARD_A_CTRL1     8'h04
`define ARD_A_INIT      8'h08
`define ARD_A_DATA      8'h0c
`define ARD_A_STATUS    8'h10
`define ARD_A_CLEAR     8'h14
`define ARD_A_ENABLE    8'h18
`define ARD_CTRL_RST    10'h000
`define ARD_F_TEST_HI   9
`define ARD_F_TEST_LO   8
`define ARD_F_REF_EXT   3
`define ARD_F_DIFF      2
`define ARD_F_RDBACK    9
`define ARD_F_TWOS      7
`define ARD_F_OVF       10
`define ARD_CODE_UPPER  12'hfff
`define ARD_CODE_MID    12'h7ff
`define ARD_CODE_LOWER  12'h000
`define ARD_CONV_DIV    3'h7
`define ARD_FIFO_DEPTH  16
`define ARD_PTR_W       4
`define ARD_CH_LAST_SE  2'h3
`define ARD_CH_LAST_DF  2'h1
`define ARD_EV_W        2
`define ARD_EV_SAMPLE   0
`define ARD_EV_RDBACK   1
`define ARD_RESP_OK     2'h0
`define ARD_RESP_ERR    2'h2

`endif

// ---- logic/ard_pkg.sv ----
/*
 Types shared by the converter debug-support block.
 Assumes nothing of its surroundings.
*/
package ard_pkg;
    typedef enum logic [1:0] {
        TEST_OFF, TEST_UPPER, TEST_MID, TEST_LOWER
    } ard_test_t;
    typedef enum logic {BUS_IDLE, BUS_RESP} ard_bus_t;
endpackage : ard_pkg

// ---- logic/ard_fifo_if.sv ----
/*
 Link between the control logic and the sample store.
 Assumes one clock shared by both ends.
*/
`include "ard_params.svh"
interface ard_fifo_if;
    logic                push;
    logic                pop;
    logic                flush;
    logic [`ARD_DW-1:0]  wdata;
    logic [`ARD_DW-1:0]  rdata;
    logic                empty;
    logic                overwrite;
    modport ctl   (output push, pop, flush, wdata,
                   input rdata, empty, overwrite);
    modport store (input push, pop, flush, wdata,
                   output rdata, empty, overwrite);
endinterface : ard_fifo_if

// ---- logic/ard_sample_fifo.sv ----
/*
 Sample store that never stalls the converter: when full, a new sample
 replaces the oldest unread one and reports the overwrite.
 Assumes the controller pops only when not empty.
*/
`include "ard_params.svh"
module ard_sample_fifo (
    // clock and reset
    input wire logic  clk_sys_in,
    input wire logic  resetn_in,
    // store side
    ard_fifo_if.store fifo
);
    logic [`ARD_DW-1:0]    mem [`ARD_FIFO_DEPTH];
    logic [`ARD_PTR_W-1:0] wp;
    logic [`ARD_PTR_W-1:0] rp;
    logic [`ARD_PTR_W:0]   count;
    logic                  full;

    assign full           = (count == `ARD_FIFO_DEPTH);
    assign fifo.empty     = (count == '0);
    assign fifo.rdata     = mem[rp];
    assign fifo.overwrite = fifo.push && full && !fifo.pop && !fifo.flush;

    always_ff @(posedge clk_sys_in) begin
        if (fifo.push && !fifo.flush) begin
            mem[wp] <= fifo.wdata;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || fifo.flush) begin
            wp    <= '0;
            rp    <= '0;
            count <= '0;
        end else begin
            if (fifo.push) begin
                wp <= wp + 1'b1;
            end
            // oldest entry is dropped so the newest always lands
            if (fifo.pop || fifo.overwrite) begin
                rp <= rp + 1'b1;
            end
            if (fifo.push && !fifo.pop && !full) begin
                count <= count + 1'b1;
            end else if (fifo.pop && !fifo.push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : ard_sample_fifo

// ---- logic/ard_top.sv ----
/*
 Debug-support logic of a pipelined converter: register read-back, test
 level selection, sample store with overflow flag, AXI4-Lite slave.
 Assumes a 40 MHz clock, the analog front end outside delivering a
 12-bit code for the selected channel on conv_code_in.
*/
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`include "ard_params.svh"
module ard_top (
    // clock and reset
    input  wire logic               clk_sys_in,
    input  wire logic               resetn_in,
    // axi4-lite write
    input  wire logic [`ARD_AW-1:0] s_axi_awaddr_in,
    input  wire logic               s_axi_awvalid_in,
    output logic                    s_axi_awready_out,
    input  wire logic [31:0]        s_axi_wdata_in,
    input  wire logic [3:0]         s_axi_wstrb_in,
    input  wire logic               s_axi_wvalid_in,
    output logic                    s_axi_wready_out,
    output logic [1:0]              s_axi_bresp_out,
    output logic                    s_axi_bvalid_out,
    input  wire logic               s_axi_bready_in,
    // axi4-lite read
    input  wire logic [`ARD_AW-1:0] s_axi_araddr_in,
    input  wire logic               s_axi_arvalid_in,
    output logic                    s_axi_arready_out,
    output logic [31:0]             s_axi_rdata_out,
    output logic [1:0]              s_axi_rresp_out,
    output logic                    s_axi_rvalid_out,
    input  wire logic               s_axi_rready_in,
    // converter side
    input  wire logic [`ARD_DW-1:0] conv_code_in,
    output logic [1:0]              channel_sel_out,
    output logic                    diff_mode_out,
    output logic                    ref_ext_sel_out,
    output ard_pkg::ard_test_t      test_sel_out,
    output logic                    sample_ready_line_out,
    output logic                    irq_out
);
    import ard_pkg::*;

    ard_fifo_if fifo_bus ();

    ard_bus_t              wr_state;
    logic                  aw_held;
    logic                  w_held;
    logic [`ARD_AW-1:0]    aw_addr;
    logic [31:0]           w_data;
    logic                  wr_fire;
    logic                  rd_fire;
    logic [`ARD_CW-1:0]    first_control_word;
    logic [`ARD_CW-1:0]    second_control_word;
    logic                  readback;
    logic                  rb_ptr;
    logic                  overflow;
    logic [`ARD_EV_W-1:0]  status;
    logic [`ARD_EV_W-1:0]  irq_en;
    logic [`ARD_EV_W-1:0]  events;
    logic [2:0]            div_cnt;
    logic                  conv_tick;
    ard_test_t             test_mode;
    logic                  init_wr;
    logic                  rb_enter;
    logic                  data_rd;
    logic [`ARD_DW-1:0]    next_sample;

    ////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic mapped(input logic [`ARD_AW-1:0] a);
        case (a)
            `ARD_A_CTRL0, `ARD_A_CTRL1, `ARD_A_INIT, `ARD_A_DATA,
            `ARD_A_STATUS, `ARD_A_CLEAR, `ARD_A_ENABLE: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction : mapped

    function automatic logic [`ARD_DW-1:0] test_code(input ard_test_t t);
        case (t)
            TEST_UPPER: test_code = `ARD_CODE_UPPER;
            TEST_MID:   test_code = `ARD_CODE_MID;
            default:    test_code = `ARD_CODE_LOWER;
        endcase
    endfunction : test_code

    ////////////////////////////////////////////////////////////////////
    // write channel: address and data taken in either order

    assign s_axi_awready_out = !aw_held && (wr_state == BUS_IDLE);
    assign s_axi_wready_out  = !w_held && (wr_state == BUS_IDLE);
    assign wr_fire  = aw_held && w_held && (wr_state == BUS_IDLE);
    assign s_axi_bvalid_out = (wr_state == BUS_RESP);

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_in;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_in;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            wr_state        <= BUS_IDLE;
            s_axi_bresp_out <= `ARD_RESP_OK;
        end else begin
            case (wr_state)
                BUS_IDLE: begin
                    if (wr_fire) begin
                        wr_state        <= BUS_RESP;
                        s_axi_bresp_out <= mapped(aw_addr) ?
                                           `ARD_RESP_OK : `ARD_RESP_ERR;
                    end
                end
                BUS_RESP: begin
                    if (s_axi_bready_in) begin
                        wr_state <= BUS_IDLE;
                    end
                end
                default: wr_state <= BUS_IDLE;
            endcase
        end
    end

    // registers are narrow: low byte lane plus bits 9:8 in lane 1
    assign init_wr  = wr_fire && (aw_addr == `ARD_A_INIT);
    assign rb_enter = wr_fire && (aw_addr == `ARD_A_CTRL1) &&
                      w_data[`ARD_F_RDBACK] && !readback;

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            first_control_word  <= `ARD_CTRL_RST;
            second_control_word <= `ARD_CTRL_RST;
            irq_en              <= '0;
        end else if (wr_fire) begin
            case (aw_addr)
                `ARD_A_CTRL0:  first_control_word  <= w_data[`ARD_CW-1:0];
                `ARD_A_CTRL1:  second_control_word <= w_data[`ARD_CW-1:0];
                `ARD_A_ENABLE: irq_en <= w_data[`ARD_EV_W-1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read-back mode

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || init_wr) begin
            readback <= 1'b0;
        end else if (rb_enter) begin
            readback <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || init_wr || rb_enter) begin
            rb_ptr <= 1'b0;
        end else if (readback && data_rd) begin
            rb_ptr <= !rb_ptr;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read channel: one outstanding read, answer one cycle after ar

    assign s_axi_arready_out = !s_axi_rvalid_out;
    assign rd_fire = s_axi_arvalid_in && s_axi_arready_out;
    assign data_rd = rd_fire && (s_axi_araddr_in == `ARD_A_DATA);

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out  <= '0;
            s_axi_rresp_out  <= `ARD_RESP_OK;
        end else if (rd_fire) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out  <= mapped(s_axi_araddr_in) ?
                                `ARD_RESP_OK : `ARD_RESP_ERR;
            s_axi_rdata_out  <= '0;
            case (s_axi_araddr_in)
                `ARD_A_CTRL0:  s_axi_rdata_out[`ARD_CW-1:0] <=
                                   first_control_word;
                `ARD_A_CTRL1:  s_axi_rdata_out[`ARD_CW-1:0] <=
                                   second_control_word;
                `ARD_A_STATUS: s_axi_rdata_out[`ARD_EV_W-1:0] <= status;
                `ARD_A_ENABLE: s_axi_rdata_out[`ARD_EV_W-1:0] <= irq_en;
                `ARD_A_DATA: begin
                    if (readback && !rb_ptr) begin
                        s_axi_rdata_out[`ARD_CW-1:0] <= first_control_word;
                    end else if (readback) begin
                        s_axi_rdata_out[`ARD_CW-1:0] <=
                            second_control_word;
                        s_axi_rdata_out[`ARD_F_OVF] <= overflow;
                    end else if (!fifo_bus.empty) begin
                        s_axi_rdata_out[`ARD_DW-1:0] <= fifo_bus.rdata;
                    end
                end
                default: ;
            endcase
        end else if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // conversion timing and sample formatting

    assign conv_tick = (div_cnt == `ARD_CONV_DIV);
    assign test_mode = ard_test_t'(first_control_word[`ARD_F_TEST_HI:
                                                      `ARD_F_TEST_LO]);

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= conv_tick ? 3'h0 : div_cnt + 3'h1;
        end
    end

    // channel order restarts on a write to the init register
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || init_wr) begin
            channel_sel_out <= '0;
        end else if (conv_tick) begin
            if (channel_sel_out == (diff_mode_out ? `ARD_CH_LAST_DF
                                                  : `ARD_CH_LAST_SE)) begin
                channel_sel_out <= '0;
            end else begin
                channel_sel_out <= channel_sel_out + 2'h1;
            end
        end
    end

    always_comb begin
        if (test_mode != TEST_OFF) begin
            next_sample = test_code(test_mode);
        end else if (second_control_word[`ARD_F_TWOS]) begin
            next_sample = {!conv_code_in[`ARD_DW-1],
                           conv_code_in[`ARD_DW-2:0]};
        end else begin
            next_sample = conv_code_in;
        end
    end

    assign diff_mode_out   = first_control_word[`ARD_F_DIFF];
    assign ref_ext_sel_out = first_control_word[`ARD_F_REF_EXT];
    assign test_sel_out    = test_mode;

    ////////////////////////////////////////////////////////////////////
    // sample store and overflow

    assign fifo_bus.push  = conv_tick;
    assign fifo_bus.wdata = next_sample;
    assign fifo_bus.flush = init_wr;
    assign fifo_bus.pop   = data_rd && !readback && !fifo_bus.empty;

    ard_sample_fifo u_store (
        .clk_sys_in (clk_sys_in),
        .resetn_in  (resetn_in),
        .fifo       (fifo_bus.store)
    );

    // overwrite is masked by the flush in the init cycle, so the clear wins
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            overflow <= 1'b0;
        end else if (fifo_bus.overwrite) begin
            overflow <= 1'b1;
        end else if (init_wr) begin
            overflow <= 1'b0;
        end
    end

    assign sample_ready_line_out = !fifo_bus.empty && !readback &&
                                   (test_mode == TEST_OFF);

    ////////////////////////////////////////////////////////////////////
    // interrupt status

    assign events[`ARD_EV_SAMPLE] = conv_tick;
    assign events[`ARD_EV_RDBACK] = rb_enter;

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            status <= '0;
        end else if (wr_fire && aw_addr == `ARD_A_CLEAR) begin
            status <= (status & ~w_data[`ARD_EV_W-1:0]) | events;
        end else begin
            status <= status | events;
        end
    end

    assign irq_out = |(status & irq_en);

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);

    a_rb_entry: assert property (rb_enter |=> readback [*2])
        else $error("read-back not entered");
    a_rb_alternate: assert property (readback && data_rd && !init_wr
        |=> rb_ptr != $past(rb_ptr))
        else $error("read-back pointer did not toggle");
    a_rb_ready_off: assert property (
        readback |-> !sample_ready_line_out)
        else $error("sample ready active in read-back");
    a_rb_hold: assert property (readback && !init_wr |=> readback)
        else $error("read-back left without init");
    a_test_ready_off: assert property (test_mode != TEST_OFF
        |-> !sample_ready_line_out)
        else $error("sample ready active in test mode");
    a_test_code: assert property (conv_tick && test_mode == TEST_MID
        |-> fifo_bus.wdata == `ARD_CODE_MID)
        else $error("wrong midpoint test code");
    a_ovf_set: assert property (fifo_bus.overwrite |=> overflow)
        else $error("overflow not set");
    a_ovf_clear: assert property (init_wr && !fifo_bus.overwrite
        |=> !overflow)
        else $error("overflow not cleared by init");
    a_rb_first: assert property ($rose(readback) |-> !rb_ptr)
        else $error("read-back pointer not at first word");

    c_rb_entry: cover property (rb_enter ##1 readback);
    c_overflow: cover property (fifo_bus.overwrite ##1 overflow);
    c_test_upper: cover property (conv_tick && test_mode == TEST_UPPER);
endmodule : ard_top

// ---- dv/ard_conv_model.sv ----
/*
 Behavioural front end of the converter: a raw code for the channel,
 input mode and reference that the block selects.
 Assumes the block samples the code on its conversion ticks.
*/
`include "ard_params.svh"
module ard_conv_model (
    // converter control from the block
    input  wire logic [1:0]         channel_sel_in,
    input  wire logic               diff_mode_in,
    input  wire logic               ref_ext_sel_in,
    // raw code to the block
    output logic [`ARD_DW-1:0]      conv_code_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // code names its source so the bench can tell samples apart
    assign conv_code_out = {4'h5, 2'h0, diff_mode_in, ref_ext_sel_in,
                            2'h0, channel_sel_in};
endmodule : ard_conv_model

// ---- dv/tb_adc_readback_test_overflow.sv ----
/*
 Self-checking bench: register, stream, test-level, read-back and
 overflow sequences over AXI4-Lite.
 Assumes the design and the converter model compiled before it.
*/
`include "ard_params.svh"
module tb_adc_readback_test_overflow;
    timeunit 1ns;
    timeprecision 100ps;
    import ard_pkg::*;

    logic              clk_sys = 1'b0;
    logic              resetn = 1'b0;
    logic [7:0]        awaddr = 8'h00;
    logic              awvalid = 1'b0;
    logic [31:0]       wdata = 32'h0;
    logic              wvalid = 1'b0;
    logic [7:0]        araddr = 8'h00;
    logic              arvalid = 1'b0;
    logic              aw_ready, w_ready, b_valid, ar_ready, r_valid;
    logic [1:0]        b_resp, r_resp, chan;
    logic [31:0]       r_data;
    logic [11:0]       code;
    logic              diff, ref_ext, smp_rdy, irq;
    ard_test_t         tsel;
    int                miscompares = 0;
    int                n_compared = 0;
    int                cycles = 0;
    logic [11:0]       lvl [1:3] = '{12'hfff, 12'h7ff, 12'h000};

    always #12.5 clk_sys = ~clk_sys;

    ard_conv_model ard_conv_model_inst (
        .channel_sel_in (chan), .diff_mode_in (diff),
        .ref_ext_sel_in (ref_ext), .conv_code_out (code));

    // responses always accepted at once
    ard_top ard_top_inst (
        .clk_sys_in (clk_sys), .resetn_in (resetn),
        .s_axi_awaddr_in (awaddr), .s_axi_awvalid_in (awvalid),
        .s_axi_awready_out (aw_ready), .s_axi_wdata_in (wdata),
        .s_axi_wstrb_in (4'hf), .s_axi_wvalid_in (wvalid),
        .s_axi_wready_out (w_ready), .s_axi_bresp_out (b_resp),
        .s_axi_bvalid_out (b_valid), .s_axi_bready_in (1'b1),
        .s_axi_araddr_in (araddr), .s_axi_arvalid_in (arvalid),
        .s_axi_arready_out (ar_ready), .s_axi_rdata_out (r_data),
        .s_axi_rresp_out (r_resp), .s_axi_rvalid_out (r_valid),
        .s_axi_rready_in (1'b1), .conv_code_in (code),
        .channel_sel_out (chan), .diff_mode_out (diff),
        .ref_ext_sel_out (ref_ext), .test_sel_out (tsel),
        .sample_ready_line_out (smp_rdy), .irq_out (irq));

    ////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("compared %0d, wrong %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        logic got;
        got = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!got) begin
            @(posedge clk_sys);
            if (awvalid && aw_ready) awvalid <= 1'b0;
            if (wvalid && w_ready) wvalid <= 1'b0;
            if (b_valid) begin
                r = b_resp;
                got = 1'b1;
            end
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        logic got;
        got = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        while (!got) begin
            @(posedge clk_sys);
            if (arvalid && ar_ready) arvalid <= 1'b0;
            if (r_valid) begin
                d = r_data;
                r = r_resp;
                got = 1'b1;
            end
        end
    endtask : axi_rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        chk("write response", {30'h0, r}, {30'h0, `ARD_RESP_OK});
    endtask : wr

    task automatic rdc(input string what, input logic [7:0] a,
                       input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        chk(what, d, exp);
        chk("read response", {30'h0, r}, {30'h0, `ARD_RESP_OK});
    endtask : rdc

    // channel order checked relative to the first sample read
    task automatic stream(input logic [2:0] n, input logic [11:0] base);
        logic [31:0] d;
        logic [1:0]  r;
        logic [1:0]  ch;
        axi_rd(`ARD_A_DATA, d, r);
        ch = d[1:0];
        chk("sample source", d & 32'hfffffffc, {20'h0, base});
        chk("channel in range", {31'h0, ch < n}, 32'h1);
        repeat (4) begin
            ch = 2'((ch + 3'h1) % n);
            axi_rd(`ARD_A_DATA, d, r);
            chk("channel order", d, {20'h0, base | ch});
        end
    endtask : stream

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        rdc("ctrl0 reset", `ARD_A_CTRL0, 32'h0);
        rdc("ctrl1 reset", `ARD_A_CTRL1, 32'h0);
        rdc("enable reset", `ARD_A_ENABLE, 32'h0);
        rdc("clear reads zero", `ARD_A_CLEAR, 32'h0);
        chk("irq after reset", {31'h0, irq}, 32'h0);
        axi_rd(8'h1c, d, r);
        chk("unmapped read", {d[29:0], r}, {30'h0, `ARD_RESP_ERR});
        axi_wr(8'h1c, 32'h3ff, r);
        chk("unmapped write", {30'h0, r}, {30'h0, `ARD_RESP_ERR});
        // single-ended, straight binary
        wr(`ARD_A_INIT, 32'h0);
        repeat (48) @(posedge clk_sys);
        chk("ready normal", {31'h0, smp_rdy}, 32'h1);
        stream(3'h4, 12'h500);
        // differential, twos complement flips the msb
        wr(`ARD_A_CTRL0, 32'h004);
        wr(`ARD_A_CTRL1, 32'h080);
        wr(`ARD_A_INIT, 32'h0);
        repeat (48) @(posedge clk_sys);
        chk("diff mode out", {31'h0, diff}, 32'h1);
        stream(3'h2, 12'hd20);
        // test levels with twos set and external reference
        for (int t = 1; t <= 3; t++) begin
            wr(`ARD_A_CTRL0, {22'h0, t[1:0], 8'h08});
            wr(`ARD_A_INIT, 32'h0);
            repeat (40) @(posedge clk_sys);
            chk("test select", {30'h0, tsel}, t);
            chk("ref select", {31'h0, ref_ext}, 32'h1);
            chk("ready in test", {31'h0, smp_rdy}, 32'h0);
            rdc("test code", `ARD_A_DATA, {20'h0, lvl[t]});
        end
        // read-back with interrupt on entry
        wr(`ARD_A_ENABLE, 32'h2);
        wr(`ARD_A_CTRL0, 32'h00c);
        chk("irq before", {31'h0, irq}, 32'h0);
        wr(`ARD_A_CTRL1, 32'h280);
        chk("irq on entry", {31'h0, irq}, 32'h1);
        rdc("rb first", `ARD_A_DATA, 32'h00c);
        rdc("rb second", `ARD_A_DATA, 32'h280);
        rdc("rb third", `ARD_A_DATA, 32'h00c);
        chk("ready in rb", {31'h0, smp_rdy}, 32'h0);
        wr(`ARD_A_CTRL1, 32'h080);
        rdc("rb stays", `ARD_A_DATA, 32'h080);
        // store overruns while read-back holds it unread
        repeat (200) @(posedge clk_sys);
        chk("ready full rb", {31'h0, smp_rdy}, 32'h0);
        rdc("rb ctrl0", `ARD_A_DATA, 32'h00c);
        rdc("rb overflow", `ARD_A_DATA, 32'h480);
        rdc("ctrl1 plain", `ARD_A_CTRL1, 32'h080);
        axi_rd(`ARD_A_STATUS, d, r);
        chk("status entry", d & 32'h2, 32'h2);
        wr(`ARD_A_CLEAR, 32'h2);
        axi_rd(`ARD_A_STATUS, d, r);
        chk("status cleared", d & 32'h2, 32'h0);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        // initialization leaves read-back and clears overflow
        wr(`ARD_A_INIT, 32'h0);
        repeat (24) @(posedge clk_sys);
        chk("ready again", {31'h0, smp_rdy}, 32'h1);
        wr(`ARD_A_CTRL1, 32'h280);
        rdc("rb restart", `ARD_A_DATA, 32'h00c);
        rdc("rb no overflow", `ARD_A_DATA, 32'h280);
        tally_and_finish();
    end
endmodule : tb_adc_readback_test_overflow
